// [verilog/amb_pkg.sv]
// Purpose: shared constants and types for the master port and its local slave end
// Assumes: single 100 MHz clock, active-low asynchronous reset
// Notes: widths fixed at configured values
package amb_pkg;
   localparam int ID_W = 4;
   localparam int USER_W = 2;
   localparam int DATA_W = 32;
   localparam int STRB_W = DATA_W / 8;
   localparam int ADDR_W = 32;
   localparam int LEN_W = 8;
   localparam int SIZE_W = 2;
   localparam int BURST_W = 2;
   localparam int RESP_W = 2;
   localparam int BUF_DEPTH = 2;
   localparam logic [RESP_W-1:0] RESP_OKAY = 2'h0;
   localparam logic [RESP_W-1:0] RESP_EXOKAY = 2'h1;
   localparam logic [RESP_W-1:0] RESP_SLVERR = 2'h2;
   localparam logic [RESP_W-1:0] RESP_DECERR = 2'h3;
   localparam logic [BURST_W-1:0] BURST_INCR = 2'h1;
   localparam logic [SIZE_W-1:0] SIZE_WORD = 2'h2;
   typedef enum logic [1:0] {AMB_W_IDLE, AMB_W_DATA, AMB_W_RESP} amb_wstate_t;
endpackage : amb_pkg

// [verilog/amb_if.sv]
// Purpose: write address, write data, write response and read address channels
// Assumes: one clock shared by both ends
// Notes: master modport is the bridge side, slave modport the local system
`timescale 1ns/1ns
interface amb_if;
   logic [amb_pkg::ID_W-1:0] awid;
   logic [amb_pkg::ADDR_W-1:0] awaddr;
   logic [amb_pkg::LEN_W-1:0] awlen;
   logic [amb_pkg::SIZE_W-1:0] awsize;
   logic [amb_pkg::BURST_W-1:0] awburst;
   logic awvalid;
   logic awready;
   logic [amb_pkg::USER_W-1:0] wuser;
   logic [amb_pkg::DATA_W-1:0] wdata;
   logic [amb_pkg::STRB_W-1:0] wstrb;
   logic wlast;
   logic wvalid;
   logic wready;
   logic [amb_pkg::ID_W-1:0] bid;
   logic [amb_pkg::RESP_W-1:0] bresp;
   logic bvalid;
   logic bready;
   logic [amb_pkg::ID_W-1:0] arid;
   logic [amb_pkg::ADDR_W-1:0] araddr;
   logic [amb_pkg::LEN_W-1:0] arlen;
   logic [amb_pkg::SIZE_W-1:0] arsize;
   logic [amb_pkg::BURST_W-1:0] arburst;
   logic arvalid;
   logic arready;
   modport master (
      output awid, awaddr, awlen, awsize, awburst, awvalid, input awready,
      output wuser, wdata, wstrb, wlast, wvalid, input wready,
      input bid, bresp, bvalid, output bready,
      output arid, araddr, arlen, arsize, arburst, arvalid, input arready
   );
   modport slave (
      input awid, awaddr, awlen, awsize, awburst, awvalid, output awready,
      input wuser, wdata, wstrb, wlast, wvalid, output wready,
      output bid, bresp, bvalid, input bready,
      input arid, araddr, arlen, arsize, arburst, arvalid, output arready
   );
endinterface : amb_if

// [verilog/amb_skid_buf.sv]
// Purpose: two-entry valid/ready buffer
// Assumes: same clock on both sides
// Notes: in_ready is registered-state based, so a drain stall never drops a word
`timescale 1ns/1ns
module amb_skid_buf #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // fill side
   input wire logic i_valid,
   input wire logic [WIDTH-1:0] i_data,
   output logic o_ready,
   // drain side
   output logic o_valid,
   output logic [WIDTH-1:0] o_data,
   input wire logic i_ready
);
   logic [WIDTH-1:0] mem_r [amb_pkg::BUF_DEPTH];
   logic rd_ptr_r;
   logic wr_ptr_r;
   logic [1:0] count_r;
   logic push;
   logic pop;

   assign o_ready = (count_r != 2'h2);
   assign o_valid = (count_r != 2'h0);
   assign push = i_valid && o_ready;
   assign pop = o_valid && i_ready;
   assign o_data = mem_r[rd_ptr_r];

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem_r[wr_ptr_r] <= i_data;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_ptr_r <= 1'b0;
         rd_ptr_r <= 1'b0;
         count_r <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr_r <= ~wr_ptr_r;
         end
         if (pop) begin
            rd_ptr_r <= ~rd_ptr_r;
         end
         count_r <= count_r + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule : amb_skid_buf

// [verilog/amb_master.sv]
// Purpose: bridge-side master port driving write and read bursts into the local system
// Assumes: i_clk is the externally supplied bus clock, i_rst_n may assert asynchronously
// Notes: write data passes a two-entry buffer; one write burst outstanding at a time
`timescale 1ns/1ns
module amb_master (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // user write command
   input wire logic i_wcmd_valid,
   output logic o_wcmd_ready,
   input wire logic [amb_pkg::ID_W-1:0] i_wcmd_id,
   input wire logic [amb_pkg::ADDR_W-1:0] i_wcmd_addr,
   input wire logic [amb_pkg::LEN_W-1:0] i_wcmd_len,
   input wire logic [amb_pkg::SIZE_W-1:0] i_wcmd_size,
   input wire logic [amb_pkg::BURST_W-1:0] i_wcmd_burst,
   // user write data
   input wire logic i_wd_valid,
   output logic o_wd_ready,
   input wire logic [amb_pkg::DATA_W-1:0] i_wd_data,
   input wire logic [amb_pkg::STRB_W-1:0] i_wd_strb,
   input wire logic [amb_pkg::USER_W-1:0] i_wd_user,
   // user write result
   output logic o_wres_valid,
   output logic [amb_pkg::ID_W-1:0] o_wres_id,
   output logic [amb_pkg::RESP_W-1:0] o_wres_resp,
   // user read command
   input wire logic i_rcmd_valid,
   output logic o_rcmd_ready,
   input wire logic [amb_pkg::ID_W-1:0] i_rcmd_id,
   input wire logic [amb_pkg::ADDR_W-1:0] i_rcmd_addr,
   input wire logic [amb_pkg::LEN_W-1:0] i_rcmd_len,
   input wire logic [amb_pkg::SIZE_W-1:0] i_rcmd_size,
   input wire logic [amb_pkg::BURST_W-1:0] i_rcmd_burst,
   // local bus
   amb_if.master bus
);
   localparam int BUF_W = amb_pkg::DATA_W + amb_pkg::STRB_W + amb_pkg::USER_W;

   amb_pkg::amb_wstate_t wstate_r;
   logic aw_pend_r;
   logic [amb_pkg::LEN_W-1:0] beats_left_r;
   logic buf_valid;
   logic [BUF_W-1:0] buf_data;
   logic buf_ready;
   logic w_fire;
   logic wcmd_take;
   logic rcmd_take;
   logic b_fire;

   // a write command is taken only while no burst is in flight
   assign o_wcmd_ready = (wstate_r == amb_pkg::AMB_W_IDLE);
   assign wcmd_take = i_wcmd_valid && o_wcmd_ready;

   // write address valid: raised on capture, dropped on the ready edge
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         aw_pend_r <= 1'b0;
      end else if (wcmd_take) begin
         aw_pend_r <= 1'b1;
      end else if (aw_pend_r && bus.awready) begin
         aw_pend_r <= 1'b0;
      end
   end
   assign bus.awvalid = aw_pend_r;

   // write address fields only move on capture, so they stand while valid is high
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         bus.awid <= '0;
         bus.awaddr <= '0;
         bus.awlen <= '0;
         bus.awsize <= amb_pkg::SIZE_WORD;
         bus.awburst <= amb_pkg::BURST_INCR;
      end else if (wcmd_take) begin
         bus.awid <= i_wcmd_id;
         bus.awaddr <= i_wcmd_addr;
         bus.awlen <= i_wcmd_len;
         bus.awsize <= i_wcmd_size;
         bus.awburst <= i_wcmd_burst;
      end
   end

   // write burst sequencing and beat count
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wstate_r <= amb_pkg::AMB_W_IDLE;
         beats_left_r <= '0;
      end else begin
         case (wstate_r)
            amb_pkg::AMB_W_IDLE: begin
               if (i_wcmd_valid) begin
                  wstate_r <= amb_pkg::AMB_W_DATA;
                  beats_left_r <= i_wcmd_len;
               end
            end
            amb_pkg::AMB_W_DATA: begin
               if (w_fire) begin
                  if (beats_left_r == '0) begin
                     wstate_r <= amb_pkg::AMB_W_RESP;
                  end else begin
                     beats_left_r <= beats_left_r - 8'h01;
                  end
               end
            end
            amb_pkg::AMB_W_RESP: begin
               if (bus.bvalid && !aw_pend_r) begin
                  wstate_r <= amb_pkg::AMB_W_IDLE;
               end
            end
            default: wstate_r <= amb_pkg::AMB_W_IDLE;
         endcase
      end
   end

   // write data through the two-entry buffer
   amb_skid_buf #(
      .WIDTH(BUF_W)
   ) u_wbuf (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_valid(i_wd_valid),
      .i_data({i_wd_user, i_wd_strb, i_wd_data}),
      .o_ready(o_wd_ready),
      .o_valid(buf_valid),
      .o_data(buf_data),
      .i_ready(buf_ready)
   );
   assign bus.wvalid = buf_valid && (wstate_r == amb_pkg::AMB_W_DATA);
   assign buf_ready = bus.wready && (wstate_r == amb_pkg::AMB_W_DATA);
   assign w_fire = bus.wvalid && bus.wready;
   assign bus.wdata = buf_data[amb_pkg::DATA_W-1:0];
   assign bus.wstrb = buf_data[amb_pkg::DATA_W +: amb_pkg::STRB_W];
   assign bus.wuser = buf_data[amb_pkg::DATA_W + amb_pkg::STRB_W +: amb_pkg::USER_W];
   assign bus.wlast = (wstate_r == amb_pkg::AMB_W_DATA) && (beats_left_r == '0);

   // write response: accept only once address has gone out
   assign bus.bready = (wstate_r == amb_pkg::AMB_W_RESP) && !aw_pend_r;
   assign b_fire = bus.bvalid && bus.bready;
   // result pulse lasts one cycle per accepted response
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_wres_valid <= 1'b0;
      end else begin
         o_wres_valid <= b_fire;
      end
   end
   // result fields hold until the next response
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_wres_id <= '0;
         o_wres_resp <= amb_pkg::RESP_OKAY;
      end else if (b_fire) begin
         o_wres_id <= bus.bid;
         o_wres_resp <= bus.bresp;
      end
   end

   // read address channel: one address at a time
   assign o_rcmd_ready = !bus.arvalid;
   assign rcmd_take = i_rcmd_valid && o_rcmd_ready;

   // read address valid: raised on capture, dropped on the ready edge
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         bus.arvalid <= 1'b0;
      end else if (rcmd_take) begin
         bus.arvalid <= 1'b1;
      end else if (bus.arvalid && bus.arready) begin
         bus.arvalid <= 1'b0;
      end
   end

   // read address fields only move on capture, so they stand while valid is high
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         bus.arid <= '0;
         bus.araddr <= '0;
         bus.arlen <= '0;
         bus.arsize <= amb_pkg::SIZE_WORD;
         bus.arburst <= amb_pkg::BURST_INCR;
      end else if (rcmd_take) begin
         bus.arid <= i_rcmd_id;
         bus.araddr <= i_rcmd_addr;
         bus.arlen <= i_rcmd_len;
         bus.arsize <= i_rcmd_size;
         bus.arburst <= i_rcmd_burst;
      end
   end
endmodule : amb_master

// [verilog/amb_local_slave.sv]
// Purpose: local-system slave end answering the master port
// Assumes: same clock as the master end
// Notes: one write burst tracked at a time; read addresses are only logged
`timescale 1ns/1ns
module amb_local_slave (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // user controls
   input wire logic i_aw_accept,
   input wire logic i_w_accept,
   input wire logic i_ar_accept,
   input wire logic [amb_pkg::RESP_W-1:0] i_resp_code,
   // user observation
   output logic o_wbeat_valid,
   output logic [amb_pkg::DATA_W-1:0] o_wbeat_data,
   output logic [amb_pkg::STRB_W-1:0] o_wbeat_strb,
   output logic o_wbeat_last,
   output logic o_rd_addr_valid,
   output logic [amb_pkg::ADDR_W-1:0] o_rd_addr,
   // local bus
   amb_if.slave bus
);
   logic aw_held_r;
   logic w_done_r;
   logic [amb_pkg::ID_W-1:0] id_r;

   assign bus.awready = i_aw_accept && !aw_held_r;
   assign bus.wready = i_w_accept && !w_done_r;
   assign bus.arready = i_ar_accept;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         aw_held_r <= 1'b0;
         w_done_r <= 1'b0;
         id_r <= '0;
         bus.bvalid <= 1'b0;
         bus.bid <= '0;
         bus.bresp <= amb_pkg::RESP_OKAY;
      end else begin
         if (bus.awvalid && bus.awready) begin
            aw_held_r <= 1'b1;
            id_r <= bus.awid;
         end
         if (bus.wvalid && bus.wready && bus.wlast) begin
            w_done_r <= 1'b1;
         end
         if (bus.bvalid && bus.bready) begin
            bus.bvalid <= 1'b0;
            aw_held_r <= 1'b0;
            w_done_r <= 1'b0;
         end else if (!bus.bvalid && aw_held_r && w_done_r) begin
            bus.bvalid <= 1'b1;
            bus.bid <= id_r;
            bus.bresp <= i_resp_code;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_wbeat_valid <= 1'b0;
         o_wbeat_data <= '0;
         o_wbeat_strb <= '0;
         o_wbeat_last <= 1'b0;
         o_rd_addr_valid <= 1'b0;
         o_rd_addr <= '0;
      end else begin
         o_wbeat_valid <= bus.wvalid && bus.wready;
         o_wbeat_data <= bus.wdata;
         o_wbeat_strb <= bus.wstrb;
         o_wbeat_last <= bus.wlast;
         o_rd_addr_valid <= bus.arvalid && bus.arready;
         o_rd_addr <= bus.araddr;
      end
   end
endmodule : amb_local_slave

// [tb/amb_chk.sv]
// Purpose: protocol checks on the bus between master port and local slave end
// Assumes: one clock, asynchronous active-low reset
// Notes: captured id, length and a beat count are helper state
`timescale 1ns/1ns
module amb_chk (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // bus signals
   input wire logic [amb_pkg::ID_W-1:0] awid,
   input wire logic [amb_pkg::ADDR_W-1:0] awaddr,
   input wire logic [amb_pkg::LEN_W-1:0] awlen,
   input wire logic [amb_pkg::SIZE_W-1:0] awsize,
   input wire logic [amb_pkg::BURST_W-1:0] awburst,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic [amb_pkg::USER_W-1:0] wuser,
   input wire logic [amb_pkg::DATA_W-1:0] wdata,
   input wire logic [amb_pkg::STRB_W-1:0] wstrb,
   input wire logic wlast,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [amb_pkg::ID_W-1:0] bid,
   input wire logic [amb_pkg::RESP_W-1:0] bresp,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [amb_pkg::ID_W-1:0] arid,
   input wire logic [amb_pkg::ADDR_W-1:0] araddr,
   input wire logic [amb_pkg::LEN_W-1:0] arlen,
   input wire logic [amb_pkg::SIZE_W-1:0] arsize,
   input wire logic [amb_pkg::BURST_W-1:0] arburst,
   input wire logic arvalid,
   input wire logic arready
);
   logic [amb_pkg::ID_W-1:0] id_r;
   logic [amb_pkg::LEN_W-1:0] len_r;
   logic [amb_pkg::LEN_W-1:0] beat_r;
   logic [amb_pkg::LEN_W-1:0] len_cur;
   // beats may be taken before the address handshake
   assign len_cur = awvalid ? awlen : len_r;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         id_r <= 4'h0;
         len_r <= 8'h00;
      end else if (awvalid && awready) begin
         id_r <= awid;
         len_r <= awlen;
      end
   end
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         beat_r <= 8'h00;
      end else if (wvalid && wready) begin
         beat_r <= wlast ? 8'h00 : beat_r + 8'h01;
      end
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   a_aw_hold_stable: assert property (awvalid && !awready |=> awvalid && $stable({awid, awaddr, awlen, awsize, awburst}))
      else $error("write address moved before ready");
   a_ar_hold_stable: assert property (arvalid && !arready |=> arvalid && $stable({arid, araddr, arlen, arsize, arburst}))
      else $error("read address moved before ready");
   a_w_hold_stable: assert property (wvalid && !wready |=> wvalid && $stable({wdata, wstrb, wuser, wlast}))
      else $error("write beat moved before ready");
   a_wlast_on_count: assert property (wvalid |-> wlast == (beat_r == len_cur))
      else $error("last flag off the burst count");
   a_bid_matches: assert property (bvalid |-> bid == id_r)
      else $error("response id differs from address id");
   a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable({bid, bresp}))
      else $error("response dropped before ready");
   a_bready_after_aw: assert property (bready |-> !awvalid)
      else $error("response ready before address taken");
   a_aw_single_shot: assert property (awvalid && awready |=> !awvalid)
      else $error("write address repeated");
   a_ar_single_shot: assert property (arvalid && arready |=> !arvalid)
      else $error("read address repeated");
endmodule : amb_chk

// [tb/tb_axi4_master_port_bridge_side.sv]
// Purpose: random and corner-case bursts through master port and slave end
// Assumes: 100 MHz clock, inputs driven at falling edges
// Notes: size and burst type are drawn at random; the master end only carries them through and the slave end ignores them
`timescale 1ns/1ns
module tb_axi4_master_port_bridge_side;
   logic i_clk, i_rst_n, stall;
   logic wc_v, wc_r, wd_v, wd_r, wres_v, rc_v, rc_r, aw_acc, w_acc, ar_acc, wb_v, wb_last, rda_v;
   logic [3:0] wc_id, rc_id, wres_id, wd_strb, wb_strb;
   logic [31:0] wc_addr, rc_addr, rda, wd_data, wb_data;
   logic [7:0] wc_len, rc_len;
   logic [1:0] wd_user, wres_resp, rcode, wb_user, wc_size, wc_burst, rc_size, rc_burst;
   logic [38:0] exp_q[$];
   logic [31:0] rd_q[$];
   logic [47:0] aw_exp, aw_seen, ar_seen;
   logic [47:0] ar_q[$];
   int miscompares, cmp_count;
   amb_if i_amb_if();
   amb_master i_amb_master (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_wcmd_valid(wc_v), .o_wcmd_ready(wc_r),
      .i_wcmd_id(wc_id), .i_wcmd_addr(wc_addr), .i_wcmd_len(wc_len), .i_wcmd_size(wc_size),
      .i_wcmd_burst(wc_burst), .i_wd_valid(wd_v), .o_wd_ready(wd_r), .i_wd_data(wd_data),
      .i_wd_strb(wd_strb), .i_wd_user(wd_user), .o_wres_valid(wres_v), .o_wres_id(wres_id),
      .o_wres_resp(wres_resp), .i_rcmd_valid(rc_v), .o_rcmd_ready(rc_r), .i_rcmd_id(rc_id),
      .i_rcmd_addr(rc_addr), .i_rcmd_len(rc_len), .i_rcmd_size(rc_size),
      .i_rcmd_burst(rc_burst), .bus(i_amb_if));
   amb_local_slave i_amb_local_slave (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_aw_accept(aw_acc),
      .i_w_accept(w_acc), .i_ar_accept(ar_acc), .i_resp_code(rcode), .o_wbeat_valid(wb_v),
      .o_wbeat_data(wb_data), .o_wbeat_strb(wb_strb), .o_wbeat_last(wb_last), .o_rd_addr_valid(rda_v),
      .o_rd_addr(rda), .bus(i_amb_if));
   amb_chk i_amb_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .awid(i_amb_if.awid), .awaddr(i_amb_if.awaddr),
      .awlen(i_amb_if.awlen), .awsize(i_amb_if.awsize), .awburst(i_amb_if.awburst), .awvalid(i_amb_if.awvalid),
      .awready(i_amb_if.awready), .wuser(i_amb_if.wuser), .wdata(i_amb_if.wdata), .wstrb(i_amb_if.wstrb),
      .wlast(i_amb_if.wlast), .wvalid(i_amb_if.wvalid), .wready(i_amb_if.wready), .bid(i_amb_if.bid),
      .bresp(i_amb_if.bresp), .bvalid(i_amb_if.bvalid), .bready(i_amb_if.bready), .arid(i_amb_if.arid),
      .araddr(i_amb_if.araddr), .arlen(i_amb_if.arlen), .arsize(i_amb_if.arsize),
      .arburst(i_amb_if.arburst), .arvalid(i_amb_if.arvalid), .arready(i_amb_if.arready));
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   task automatic note(input logic ok, input string what);
      cmp_count++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("MISMATCH at %0t: %s", $time, what);
      end
   endtask : note
   task automatic cmp_beat(input logic [38:0] got, input logic [38:0] exp);
      note(got === exp, "write beat");
   endtask : cmp_beat
   task automatic cmp_resp(input logic [5:0] got, input logic [5:0] exp);
      note(got === exp, "write result");
   endtask : cmp_resp
   task automatic cmp_addr(input logic [31:0] got, input logic [31:0] exp);
      note(got === exp, "read address");
   endtask : cmp_addr
   task automatic cmp_cmd(input logic [47:0] got, input logic [47:0] exp);
      note(got === exp, "address fields");
   endtask : cmp_cmd
   task automatic cmp_flag(input logic got, input logic exp);
      note(got === exp, "flag");
   endtask : cmp_flag
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : tally_and_finish
   task automatic wait_hi(ref logic sig);
      int n;
      n = 0;
      do begin
         @(posedge i_clk);
         n++;
      end while (sig !== 1'b1 && n < 3000);
      if (n >= 3000) cmp_flag(1'b0, 1'b1);
   endtask : wait_hi
   task automatic push_words(input int first, input int len);
      for (int i = first; i <= len; i++) begin
         @(negedge i_clk);
         wd_v = 1'b1;
         wd_data = $urandom;
         wd_strb = 4'($urandom);
         wd_user = 2'($urandom);
         wait_hi(wd_r);
         exp_q.push_back({wd_data, wd_strb, wd_user, i == len});
      end
      @(negedge i_clk);
      wd_v = 1'b0;
   endtask : push_words
   task automatic write_burst(input logic [3:0] id, input logic [7:0] len, input logic [1:0] code, input int first);
      fork
         begin
            @(negedge i_clk);
            wc_v = 1'b1;
            wc_id = id;
            wc_addr = $urandom;
            wc_len = len;
            wc_size = 2'($urandom % 3);
            wc_burst = 2'($urandom % 3);
            aw_exp = {id, wc_addr, len, wc_size, wc_burst};
            rcode = code;
            wait_hi(wc_r);
            @(negedge i_clk);
            wc_v = 1'b0;
         end
         if (first <= int'(len)) push_words(first, int'(len));
      join
      wait_hi(wres_v);
      cmp_resp({wres_id, wres_resp}, {id, code});
   endtask : write_burst
   always @(negedge i_clk) begin
      aw_acc <= ($urandom % 4) != 0;
      w_acc <= !stall && (($urandom % 3) != 0);
      ar_acc <= ($urandom % 2) != 0;
   end
   assign aw_seen = {i_amb_if.awid, i_amb_if.awaddr, i_amb_if.awlen, i_amb_if.awsize, i_amb_if.awburst};
   assign ar_seen = {i_amb_if.arid, i_amb_if.araddr, i_amb_if.arlen, i_amb_if.arsize, i_amb_if.arburst};
   always @(posedge i_clk) begin
      // user sideband logged like the slave's beat outputs, one cycle after the handshake
      wb_user <= i_amb_if.wuser;
      if (wb_v === 1'b1) cmp_beat({wb_data, wb_strb, wb_user, wb_last}, exp_q.pop_front());
      if (rda_v === 1'b1) cmp_addr(rda, rd_q.pop_front());
      if (i_amb_if.awvalid === 1'b1 && i_amb_if.awready === 1'b1) cmp_cmd(aw_seen, aw_exp);
      if (i_amb_if.arvalid === 1'b1 && i_amb_if.arready === 1'b1) cmp_cmd(ar_seen, ar_q.pop_front());
   end
   initial begin
      // generous bound over all bursts, including the 256-beat one
      #500000;
      note(1'b0, "timeout");
      tally_and_finish();
   end
   initial begin
      {i_rst_n, wc_v, wd_v, rc_v, aw_acc, w_acc, ar_acc, wc_id, rc_id, wd_strb, wd_user, rcode} = '0;
      {wc_addr, rc_addr, wd_data, wc_len, rc_len, wc_size, wc_burst, rc_size, rc_burst} = '0;
      stall = 1'b1;
      void'($urandom(24));
      repeat (3) @(posedge i_clk);
      cmp_flag(i_amb_if.awvalid | i_amb_if.wvalid | i_amb_if.bvalid | i_amb_if.arvalid, 1'b0);
      @(negedge i_clk);
      i_rst_n = 1'b1;
      $display("reset test done");
      push_words(0, 1);
      repeat (2) @(negedge i_clk);
      cmp_flag(wd_r, 1'b0);
      cmp_flag(i_amb_if.wvalid, 1'b0);
      fork
         write_burst(4'h3, 8'h01, amb_pkg::RESP_OKAY, 2);
         begin
            repeat (8) @(negedge i_clk);
            stall = 1'b0;
         end
      join
      $display("stall test done");
      fork
         // k = 0 gives the single-beat corner, k = 1 the longest burst
         for (int k = 0; k < 16; k++) write_burst(4'($urandom), k == 1 ? 8'hff : 8'($urandom % (k * 2 + 1)), 2'(k), 0);
         begin
            for (int j = 0; j < 24; j++) begin
               @(negedge i_clk);
               rc_v = 1'b1;
               rc_id = 4'($urandom);
               rc_addr = $urandom;
               rc_len = 8'($urandom);
               rc_size = 2'($urandom % 3);
               rc_burst = 2'($urandom % 3);
               wait_hi(rc_r);
               rd_q.push_back(rc_addr);
               ar_q.push_back({rc_id, rc_addr, rc_len, rc_size, rc_burst});
            end
            @(negedge i_clk);
            rc_v = 1'b0;
         end
      join
      repeat (6) @(posedge i_clk);
      cmp_flag(exp_q.size() == 0 && rd_q.size() == 0 && ar_q.size() == 0, 1'b1);
      $display("burst test done");
      tally_and_finish();
   end
endmodule : tb_axi4_master_port_bridge_side
